// ### core/csa_pkg.sv
// ****************************************************************
// Shared types and constants of the shift and compare datapath
// ****************************************************************
package csa_pkg;

  // Widths of the datapath
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned REG_CNT = 8;

  // Shift count limits
  localparam logic [4:0] SHIFT_MAX = 5'h10;
  localparam logic [15:0] SRC_CNT_LIMIT = 16'h000f;

  // Sign bit position and byte sign position
  localparam int unsigned SIGN_POS = 15;
  localparam int unsigned BYTE_SIGN_POS = 7;

  // APB map: flags word, then general registers one word each
  localparam logic [7:0] FLAGS_OFS = 8'h00;
  localparam logic [7:0] GPR_BASE_OFS = 8'h20;
  localparam logic [7:0] GPR_LAST_OFS = 8'h3c;

  // Flag field positions inside the flags word
  localparam int unsigned FLAG_C_POS = 0;
  localparam int unsigned FLAG_V_POS = 1;
  localparam int unsigned FLAG_Z_POS = 2;
  localparam int unsigned FLAG_N_POS = 3;

  // Reset values
  localparam logic [15:0] GPR_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // Operations issued by the instruction decoder
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ASR_IMM = 3'b001,
    OP_ASR_REG = 3'b010,
    OP_CMP_REG = 3'b011,
    OP_CMP_LOW = 3'b100,
    OP_CMP_HIGH = 3'b101
  } csa_op_t;

  // Condition flags
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } csa_flags_t;

  // One decoded instruction
  typedef struct packed {
    logic valid;
    csa_op_t op;
    logic [2:0] dest;
    logic [2:0] src1;
    logic [2:0] src2;
    logic [3:0] short_immediate;
    logic [7:0] imm_byte;
  } csa_instr_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } csa_apb_req_t;

  // Complete state of the datapath
  typedef struct packed {
    logic [REG_CNT-1:0][DATA_W-1:0] gpr;
    csa_flags_t flags;
    logic [DATA_W-1:0] result;
    logic done;
    logic [31:0] prdata;
  } csa_state_t;

endpackage : csa_pkg

// ### core/csa_alu.sv
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
// ****************************************************************
// Shift and compare datapath with register file and flags
// ****************************************************************
module csa_alu (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Instruction from the decoder
  input csa_pkg::csa_instr_t INSTR,
  // Execution results
  output logic [15:0] RESULT,
  output csa_pkg::csa_flags_t FLAGS,
  output logic DONE,
  // APB slave
  input csa_pkg::csa_apb_req_t APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  // ****************************************************************
  // State and operand selection
  // ****************************************************************

  // Registered state and its next value
  csa_pkg::csa_state_t st_q;
  csa_pkg::csa_state_t st_d;

  // Operands read from the register file
  logic [15:0] dest_val;
  logic [15:0] src1_val;
  logic [15:0] src2_val;

  // Shift datapath values
  logic [4:0] shift_n;
  logic [15:0] asr_res;
  logic asr_carry;

  // Compare datapath values
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic [15:0] cmp_res;
  logic [7:0] byte_a;
  logic [8:0] byte_diff;
  logic borrow_in;

  // APB decode
  logic apb_setup;
  logic apb_access;
  logic gpr_hit;
  logic flags_hit;
  logic [2:0] apb_idx;

  // Register reads; index zero never holds anything but zero
  always_comb begin
    dest_val = st_q.gpr[INSTR.dest];
    src1_val = st_q.gpr[INSTR.src1];
    src2_val = st_q.gpr[INSTR.src2];
  end

  // ****************************************************************
  // Arithmetic shift right
  // ****************************************************************

  // Count selection, saturated at sixteen in both forms
  always_comb begin
    if (INSTR.op == csa_pkg::OP_ASR_IMM) begin
      if (INSTR.short_immediate == 4'h0) begin
        shift_n = csa_pkg::SHIFT_MAX;
      end else begin
        shift_n = {1'b0, INSTR.short_immediate};
      end
    end else if (src1_val > csa_pkg::SRC_CNT_LIMIT) begin
      shift_n = csa_pkg::SHIFT_MAX;
    end else begin
      shift_n = src1_val[4:0];
    end
  end

  // Sign-filling shift; a count of sixteen leaves only sign copies
  always_comb begin
    asr_res = 16'($signed(dest_val) >>> shift_n);
    // Last bit shifted out is bit n-1 of the old value
    if (shift_n == 5'h00) begin
      asr_carry = st_q.flags.c;
    end else begin
      asr_carry = dest_val[4'(shift_n - 5'h01)];
    end
  end

  // ****************************************************************
  // Compare
  // ****************************************************************

  // Full-width subtraction for the register form
  always_comb begin
    cmp_a = src1_val;
    cmp_b = src2_val;
    cmp_res = cmp_a - cmp_b;
  end

  // Byte subtraction for the split immediate steps; the high step
  // consumes the borrow left by the low step
  always_comb begin
    if (INSTR.op == csa_pkg::OP_CMP_HIGH) begin
      byte_a = dest_val[15:8];
      borrow_in = st_q.flags.c;
    end else begin
      byte_a = dest_val[7:0];
      borrow_in = 1'b0;
    end
    byte_diff = {1'b0, byte_a} - {1'b0, INSTR.imm_byte}
      - {8'h00, borrow_in};
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // Setup latches read data, access completes in the next cycle unless a write waits on PREADY
  always_comb begin
    apb_setup = APB_REQ.psel && !APB_REQ.penable;
    apb_access = APB_REQ.psel && APB_REQ.penable;
    flags_hit = APB_REQ.paddr == csa_pkg::FLAGS_OFS;
    gpr_hit = APB_REQ.paddr >= csa_pkg::GPR_BASE_OFS
      && APB_REQ.paddr <= csa_pkg::GPR_LAST_OFS
      && APB_REQ.paddr[1:0] == 2'b00;
    apb_idx = 3'(APB_REQ.paddr[4:2]);
  end

  // A write is held off while an instruction updates state, so
  // software and the datapath never race on one register
  assign PREADY = !(INSTR.valid && APB_REQ.pwrite);
  assign PSLVERR = apb_access && !(gpr_hit || flags_hit);
  assign PRDATA = st_q.prdata;

  // ****************************************************************
  // Next state
  // ****************************************************************

  // All updates of registers, flags and outputs
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    // Software access
    if (apb_setup) begin
      if (flags_hit) begin
        st_d.prdata = {28'h0000000, st_q.flags};
      end else if (gpr_hit) begin
        st_d.prdata = {16'h0000, st_q.gpr[apb_idx]};
      end else begin
        st_d.prdata = 32'h00000000;
      end
    end
    if (apb_access && APB_REQ.pwrite && PREADY) begin
      if (flags_hit) begin
        st_d.flags = APB_REQ.pwdata[3:0];
      end else if (gpr_hit) begin
        st_d.gpr[apb_idx] = APB_REQ.pwdata[15:0];
      end
    end
    // Instruction execution
    if (INSTR.valid) begin
      case (INSTR.op)
        csa_pkg::OP_ASR_IMM, csa_pkg::OP_ASR_REG: begin
          st_d.result = asr_res;
          st_d.gpr[INSTR.dest] = asr_res;
          st_d.flags.n = asr_res[csa_pkg::SIGN_POS];
          st_d.flags.z = asr_res == 16'h0000;
          st_d.flags.v = dest_val[csa_pkg::SIGN_POS]
            ^ asr_res[csa_pkg::SIGN_POS];
          st_d.flags.c = asr_carry;
          st_d.done = 1'b1;
        end
        csa_pkg::OP_CMP_REG: begin
          // Only flags and the result move; no register takes the difference
          st_d.result = cmp_res;
          st_d.flags.n = cmp_res[csa_pkg::SIGN_POS];
          st_d.flags.z = cmp_res == 16'h0000;
          st_d.flags.v = (cmp_a[15] & ~cmp_b[15] & ~cmp_res[15])
            | (~cmp_a[15] & cmp_b[15] & cmp_res[15]);
          st_d.flags.c = (~cmp_a[15] & cmp_b[15])
            | (~cmp_a[15] & cmp_res[15])
            | (cmp_b[15] & cmp_res[15]);
          st_d.done = 1'b1;
        end
        csa_pkg::OP_CMP_LOW, csa_pkg::OP_CMP_HIGH: begin
          st_d.result = {8'h00, byte_diff[7:0]};
          st_d.flags.n = byte_diff[csa_pkg::BYTE_SIGN_POS];
          if (INSTR.op == csa_pkg::OP_CMP_HIGH) begin
            st_d.flags.z = (byte_diff[7:0] == 8'h00)
              && st_q.flags.z;
          end else begin
            st_d.flags.z = byte_diff[7:0] == 8'h00;
          end
          st_d.flags.v = (byte_a[7] & ~INSTR.imm_byte[7]
            & ~byte_diff[7]) | (~byte_a[7] & INSTR.imm_byte[7]
            & byte_diff[7]);
          st_d.flags.c = byte_diff[8];
          st_d.done = 1'b1;
        end
        default: begin
          st_d.done = 1'b0;
        end
      endcase
    end
    // The zero register discards whatever was aimed at it
    st_d.gpr[0] = csa_pkg::GPR_RST;
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign RESULT = st_q.result;
  assign FLAGS = st_q.flags;
  assign DONE = st_q.done;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  // Issue helpers
  logic is_asr;
  logic is_cmp;
  assign is_asr = INSTR.valid && (INSTR.op == csa_pkg::OP_ASR_IMM
    || INSTR.op == csa_pkg::OP_ASR_REG);
  assign is_cmp = INSTR.valid && INSTR.op == csa_pkg::OP_CMP_REG;

  // Old value with a zero below bit zero; bit zero after the shift is
  // the last bit pushed out, worked out apart from the carry mux
  logic [16:0] carry_probe;
  assign carry_probe = {dest_val, 1'b0} >> shift_n;

  // Split compare as two back to back steps
  sequence low_step_s;
    INSTR.valid && INSTR.op == csa_pkg::OP_CMP_LOW;
  endsequence
  sequence high_step_s;
    INSTR.valid && INSTR.op == csa_pkg::OP_CMP_HIGH;
  endsequence
  // The high step names the same register as the low step
  sequence same_dest_s;
    INSTR.dest == $past(INSTR.dest);
  endsequence

  // Result is the old value shifted with sign copies on top
  asr_sign_fill_a: assert property (is_asr |=>
    RESULT == 16'($signed($past(dest_val)) >>> $past(shift_n))
    && DONE)
    else $error("shift result wrong");
  // Zero in the short count field gives all sign copies
  imm_zero_a: assert property (
    INSTR.valid && INSTR.op == csa_pkg::OP_ASR_IMM
    && INSTR.short_immediate == 4'h0
    |=> RESULT == {16{$past(dest_val[15])}})
    else $error("zero immediate not sixteen");
  // Count register above fifteen also gives all sign copies
  reg_count_a: assert property (
    INSTR.valid && INSTR.op == csa_pkg::OP_ASR_REG
    && src1_val > 16'h000f |=> RESULT == {16{$past(dest_val[15])}})
    else $error("large count not sixteen");
  // Small count register values are used as they stand
  reg_count_low_a: assert property (
    INSTR.valid && INSTR.op == csa_pkg::OP_ASR_REG
    && src1_val <= 16'h000f |=> RESULT
    == 16'($signed($past(dest_val)) >>> $past(src1_val[3:0])))
    else $error("small count not used as is");
  // Carry keeps its value on a zero count
  carry_hold_a: assert property (
    is_asr && shift_n == 5'h00 && !APB_REQ.psel
    |=> FLAGS.c == $past(FLAGS.c))
    else $error("carry moved on zero shift");
  // Carry takes the last bit pushed out on a nonzero count
  carry_out_a: assert property (
    is_asr && shift_n != 5'h00
    |=> FLAGS.c == $past(carry_probe[0]))
    else $error("shift carry wrong");
  // Sign and zero follow the stored result
  nz_flags_a: assert property ((is_asr || is_cmp) |=>
    FLAGS.n == RESULT[15] && FLAGS.z == (RESULT == 16'h0000))
    else $error("sign or zero flag wrong");
  // Shift overflow compares the sign before and after
  asr_ovf_a: assert property (is_asr |=>
    FLAGS.v == ($past(dest_val[15]) ^ RESULT[15]))
    else $error("shift overflow wrong");
  // A register compare leaves the register file alone
  cmp_no_write_a: assert property (
    is_cmp && !APB_REQ.psel |=> $stable(st_q.gpr))
    else $error("compare wrote a register");
  // Byte compare steps leave the register file alone too
  byte_no_write_a: assert property (
    (low_step_s or high_step_s) and !APB_REQ.psel
    |=> $stable(st_q.gpr))
    else $error("byte compare wrote a register");
  // Register compare reports the plain difference
  cmp_sub_a: assert property (is_cmp |=>
    RESULT == 16'($past(src1_val) - $past(src2_val)))
    else $error("compare difference wrong");
  // Register zero never holds anything but zero
  zero_reg_a: assert property (st_q.gpr[0] == 16'h0000)
    else $error("zero register not zero");
  // Overflow of a register compare is signed overflow
  cmp_ovf_a: assert property (is_cmp |=> FLAGS.v ==
    (($past(src1_val[15]) != $past(src2_val[15]))
    && (RESULT[15] != $past(src1_val[15]))))
    else $error("compare overflow wrong");
  // Carry of a register compare is the unsigned borrow
  cmp_borrow_a: assert property (is_cmp |=>
    FLAGS.c == ($past(src1_val) < $past(src2_val)))
    else $error("compare borrow wrong");
  // Low step subtracts the low immediate byte with no borrow in
  split_low_a: assert property (low_step_s |=>
    RESULT == {8'h00, 8'($past(dest_val[7:0])
    - $past(INSTR.imm_byte))})
    else $error("low byte compare wrong");
  // Zero after the high step covers the whole word
  split_zero_a: assert property (
    low_step_s ##1 (high_step_s and same_dest_s and !APB_REQ.psel)
    |=> FLAGS.z == ($past(dest_val) == {$past(INSTR.imm_byte),
    $past(INSTR.imm_byte, 2)}))
    else $error("split compare zero wrong");
  // Borrow after the high step covers the whole word
  split_borrow_a: assert property (
    low_step_s ##1 (high_step_s and same_dest_s)
    |=> FLAGS.c == ($past(dest_val) < {$past(INSTR.imm_byte),
    $past(INSTR.imm_byte, 2)}))
    else $error("split compare borrow wrong");

endmodule : csa_alu

// ### dv/csa_dec_model.sv
`timescale 1ns/1ns
// ****************************************
// Decoder stand-in for the datapath
// ****************************************
module csa_dec_model (
  // Clock
  input wire logic clk,
  // Decoded instruction
  output csa_pkg::csa_instr_t instr
);
  // Quiet until the first issue
  initial begin
    instr = '0;
  end
  // One instruction per edge; idle flips stale fields
  task automatic issue(input csa_pkg::csa_instr_t i);
    csa_pkg::csa_instr_t t;
    t = ~instr;
    t.valid = 1'b0;
    t.op = csa_pkg::OP_NONE;
    @(posedge clk);
    instr <= i.valid ? i : t;
  endtask
endmodule // csa_dec_model

// ### dv/tb_coproc_shift_compare_alu.sv
`timescale 1ns/1ns
`define CSA_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
// ****************************************
// Bench of the shift and compare datapath
// ****************************************
module tb_coproc_shift_compare_alu;
  logic clk;
  logic sys_rst;
  csa_pkg::csa_instr_t instr;
  csa_pkg::csa_apb_req_t apb_q;
  logic [15:0] result;
  csa_pkg::csa_flags_t flags;
  logic done;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int errors;
  int tests_run;
  int seed;
  // Reference state: registers, flags, last result
  logic [15:0] m_r [8];
  csa_pkg::csa_flags_t m_f;
  logic [15:0] e_res;
  logic pend;
  logic [31:0] rd;
  logic er;
  csa_dec_model dec_u (.clk(clk), .instr(instr));
  csa_alu dut_u (.CLOCK(clk), .SYS_RST(sys_rst), .INSTR(instr),
    .RESULT(result), .FLAGS(flags), .DONE(done), .APB_REQ(apb_q),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic csa_pkg::csa_instr_t mk(csa_pkg::csa_op_t o,
    logic [2:0] d, logic [2:0] s1, logic [2:0] s2, logic [7:0] im);
    return '{1'b1, o, d, s1, s2, im[3:0], im};
  endfunction
  // APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] wd);
    @(posedge clk);
    apb_q <= '{1'b1, 1'b0, w, ad, wd};
    @(posedge clk);
    apb_q.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apb_q <= '0;
  endtask
  // Issue one op, check the previous one, then model this one
  task automatic exec(input csa_pkg::csa_instr_t i);
    logic [15:0] a;
    logic [16:0] d;
    int n;
    dec_u.issue(i);
    #1;
    if (pend) begin
      `CSA_CHK(done, 1'b1)
      `CSA_CHK(result, e_res)
      `CSA_CHK(flags, m_f)
    end
    pend = i.valid;
    a = m_r[i.dest];
    case (i.op)
      csa_pkg::OP_ASR_IMM, csa_pkg::OP_ASR_REG: begin
        n = i.short_immediate == 0 ? 16 : i.short_immediate;
        if (i.op == csa_pkg::OP_ASR_REG) begin
          n = m_r[i.src1] > 15 ? 16 : int'(m_r[i.src1]);
        end
        e_res = $signed(a) >>> n;
        if (n > 0) begin
          m_f.c = a[n-1];
        end
        m_f.v = a[15] ^ e_res[15];
        if (i.dest != 0) begin
          m_r[i.dest] = e_res;
        end
      end
      csa_pkg::OP_CMP_REG: begin
        d = {1'b0, m_r[i.src1]} - {1'b0, m_r[i.src2]};
        e_res = d[15:0];
        m_f.c = d[16];
        m_f.v = (m_r[i.src1][15] ^ m_r[i.src2][15]) & (d[15] ^ m_r[i.src1][15]);
      end
      csa_pkg::OP_CMP_LOW, csa_pkg::OP_CMP_HIGH: begin
        if (i.op == csa_pkg::OP_CMP_HIGH) begin
          a = {8'h00, a[15:8]};
        end
        d = {9'h000, a[7:0]} - {9'h000, i.imm_byte};
        if (i.op == csa_pkg::OP_CMP_HIGH) begin
          d = d - {16'h0000, m_f.c};
        end
        e_res = {8'h00, d[7:0]};
        m_f.z = (d[7:0] == 0) & (i.op == csa_pkg::OP_CMP_LOW | m_f.z);
        m_f.c = d[8];
        m_f.n = d[7];
        m_f.v = (a[7] ^ i.imm_byte[7]) & (d[7] ^ a[7]);
      end
      default: ;
    endcase
    if (i.op inside {csa_pkg::OP_ASR_IMM, csa_pkg::OP_ASR_REG,
      csa_pkg::OP_CMP_REG}) begin
      m_f.n = e_res[15];
      m_f.z = e_res == 0;
    end
  endtask
  // Read every register back through APB
  task automatic regs_check;
    exec('0);
    for (int r = 0; r < 8; r++) begin
      apb(1'b0, 8'h20 + 8'(4 * r), 32'h0);
      `CSA_CHK(rd, {16'h0000, m_r[r]})
    end
  endtask
  task automatic report_and_stop;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    seed = 32'hb89b;
    errors = 0;
    tests_run = 0;
    pend = 1'b0;
    apb_q = '0;
    m_f = '0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // Random preload; the write to register zero is dropped
    for (int r = 0; r < 8; r++) begin
      rd = $random(seed);
      m_r[r] = r == 0 ? 16'h0000 : {rd[15:1], 1'b1};
      apb(1'b1, 8'h20 + 8'(4 * r), {16'hffff, rd[15:1], 1'b1});
    end
    regs_check();
    apb(1'b0, 8'h10, 32'h0);
    `CSA_CHK({er, rd}, 33'h100000000)
    // Carry preset, then a zero count through register zero keeps it
    apb(1'b1, 8'h00, 32'h1);
    m_f = 4'h1;
    exec(mk(csa_pkg::OP_ASR_REG, 3'h2, 3'h0, 3'h0, 8'h00));
    for (int k = 0; k < 16; k++) begin
      exec(mk(csa_pkg::OP_ASR_IMM, 3'(k), 3'h0, 3'h0, 8'(k)));
    end
    foreach (m_r[k]) begin
      exec(mk(csa_pkg::OP_ASR_IMM, 3'(k), 3'h0, 3'h0, 8'h01));
    end
    // Count register at 15, 16 and beyond
    for (int k = 0; k < 3; k++) begin
      exec('0);
      m_r[7] = k == 0 ? 16'h000f : k == 1 ? 16'h0010 : 16'hffff;
      apb(1'b1, 8'h3c, {16'h0000, m_r[7]});
      m_r[4] = 16'h8421;
      apb(1'b1, 8'h30, 32'h8421);
      exec(mk(csa_pkg::OP_ASR_REG, 3'h4, 3'h7, 3'h0, 8'h00));
    end
    // Split compares: equal, low equal only, random
    for (int k = 0; k < 6; k++) begin
      rd = k == 0 ? m_r[3] : k == 1 ? m_r[3] ^ 16'h8000 : $random(seed);
      exec(mk(csa_pkg::OP_CMP_LOW, 3'h3, 3'h0, 3'h0, rd[7:0]));
      exec(mk(csa_pkg::OP_CMP_HIGH, 3'h3, 3'h0, 3'h0, rd[15:8]));
    end
    repeat (80) begin
      exec(mk(csa_pkg::csa_op_t'(3'(1 + $unsigned($random(seed)) % 5)),
        3'($random(seed)), 3'($random(seed)), 3'($random(seed)),
        8'($random(seed))));
    end
    // A write meeting an instruction waits until the decoder idles
    exec('0);
    fork
      apb(1'b1, 8'h34, 32'h00001234);
      begin
        @(posedge clk);
        exec(mk(csa_pkg::OP_ASR_IMM, 3'h5, 3'h0, 3'h0, 8'h03));
        exec('0);
      end
    join
    m_r[5] = 16'h1234;
    regs_check();
    apb(1'b0, 8'h00, 32'h0);
    `CSA_CHK(rd, {28'h0, m_f})
    report_and_stop();
  end
endmodule // tb_coproc_shift_compare_alu
